// [rtl/bbse_regs.svh]
// Contract
// RL1 - Selected I/O bit high skips next instruction, costing one, two or three cycles.
// RL2 - Generic flag branches test status bit s high or low; target PC+k+1, 1/2 cycles.
// RL3 - Zero branches jump when zero flag is one, or when it is zero.
// RL4 - Carry-high and unsigned-lower jump on carry one; carry-low and unsigned-ge on zero.
// RL5 - Negative branch jumps on N one, positive branch on N zero.
// RL6 - Signed ge jumps when N xor V is zero, signed lt when it is one.
// RL7 - Half-carry branches jump on H one or zero, one or two cycles.
// RL8 - T flag branches jump on T one or zero to PC+k+1.
// RL9 - Overflow branches jump on V one or zero to PC+k+1.
// RL10 - Interrupt-state branches jump on I one or zero to PC+k+1.
// RL11 - I/O bit set or clear takes two cycles, touches one bit, no flags.
// RL12 - Left shift moves bits up, zero into bit 0, updates Z C N V, one cycle.
// RL13 - Right shift moves bits down, zero into bit 7, updates Z C N V, one cycle.
// RL14 - Rotate left puts old carry in bit 0 and old bit 7 in carry.
// RL15 - Rotate right puts old carry in bit 7 and old bit 0 in carry.
// RL16 - Arithmetic right shift keeps bit 7, updates Z C N V, one cycle.
// RL17 - Bit store copies register bit to T; bit load copies T back, no flags.
// RL18 - Each set or clear flag instruction forces only that flag, one cycle.
// RL19 - Interrupt enable sets I, disable clears I, one cycle each.
// RL20 - Offsets are signed 7-bit words; taken skip costs two or three cycles.
`ifndef BBSE_REGS_SVH
`define BBSE_REGS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define BBSE_ADDR_CMD 8'h00
`define BBSE_ADDR_FLAGS 8'h04
`define BBSE_ADDR_PC 8'h08
`define BBSE_ADDR_OPND 8'h0c
`define BBSE_ADDR_IOVAL 8'h10
`define BBSE_ADDR_STAT 8'h14

// ----------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------
`define BBSE_CMD_OP_LSB 0
`define BBSE_CMD_BIT_LSB 6
`define BBSE_CMD_OFS_LSB 9
`define BBSE_CMD_TWO_WORD 16

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define BBSE_STAT_BUSY 0
`define BBSE_STAT_DONE 1
`define BBSE_STAT_TAKEN 2
`define BBSE_STAT_COST_LSB 4

// ----------------------------------------------------------------------
// Flag positions
// ----------------------------------------------------------------------
`define BBSE_FLAG_C 3'h0
`define BBSE_FLAG_Z 3'h1
`define BBSE_FLAG_N 3'h2
`define BBSE_FLAG_V 3'h3
`define BBSE_FLAG_S 3'h4
`define BBSE_FLAG_H 3'h5
`define BBSE_FLAG_T 3'h6
`define BBSE_FLAG_I 3'h7

// ----------------------------------------------------------------------
// Reset values and cycle costs
// ----------------------------------------------------------------------
`define BBSE_RST_FLAGS 8'h00
`define BBSE_RST_PC 16'h0000
`define BBSE_RST_BYTE 8'h00
`define BBSE_COST_ONE 2'h1
`define BBSE_COST_TWO 2'h2
`define BBSE_COST_THREE 2'h3

`endif

// [rtl/bbse_pkg.sv]
package bbse_pkg;

    typedef enum logic [5:0] {
        BBSE_OP_NONE = 6'h00,
        BBSE_OP_SKIP_IF_IO_BIT_HIGH = 6'h01,
        BBSE_OP_BRANCH_ON_FLAG_HIGH = 6'h02,
        BBSE_OP_BRANCH_ON_FLAG_LOW = 6'h03,
        BBSE_OP_BRANCH_ZERO_HIGH = 6'h04,
        BBSE_OP_BRANCH_ZERO_LOW = 6'h05,
        BBSE_OP_BRANCH_CARRY_HIGH = 6'h06,
        BBSE_OP_BRANCH_CARRY_LOW = 6'h07,
        BBSE_OP_BRANCH_UNSIGNED_GE = 6'h08,
        BBSE_OP_BRANCH_UNSIGNED_LT = 6'h09,
        BBSE_OP_BRANCH_NEGATIVE = 6'h0a,
        BBSE_OP_BRANCH_POSITIVE = 6'h0b,
        BBSE_OP_BRANCH_SIGNED_GE = 6'h0c,
        BBSE_OP_BRANCH_SIGNED_LT = 6'h0d,
        BBSE_OP_BRANCH_HALFCARRY_HIGH = 6'h0e,
        BBSE_OP_BRANCH_HALFCARRY_LOW = 6'h0f,
        BBSE_OP_BRANCH_TFLAG_HIGH = 6'h10,
        BBSE_OP_BRANCH_TFLAG_LOW = 6'h11,
        BBSE_OP_BRANCH_OVERFLOW_HIGH = 6'h12,
        BBSE_OP_BRANCH_OVERFLOW_LOW = 6'h13,
        BBSE_OP_BRANCH_INT_ENABLED = 6'h14,
        BBSE_OP_BRANCH_INT_DISABLED = 6'h15,
        BBSE_OP_SET_IO_BIT = 6'h16,
        BBSE_OP_CLEAR_IO_BIT = 6'h17,
        BBSE_OP_SHIFT_LEFT_LOGICAL = 6'h18,
        BBSE_OP_SHIFT_RIGHT_LOGICAL = 6'h19,
        BBSE_OP_ROTATE_LEFT_CARRY = 6'h1a,
        BBSE_OP_ROTATE_RIGHT_CARRY = 6'h1b,
        BBSE_OP_SHIFT_RIGHT_ARITH = 6'h1c,
        BBSE_OP_BIT_STORE_TO_TFLAG = 6'h1d,
        BBSE_OP_BIT_LOAD_FROM_TFLAG = 6'h1e,
        BBSE_OP_FLAG_SET = 6'h1f,
        BBSE_OP_FLAG_CLEAR = 6'h20,
        BBSE_OP_SET_CARRY = 6'h21,
        BBSE_OP_CLR_CARRY = 6'h22,
        BBSE_OP_SET_NEGATIVE = 6'h23,
        BBSE_OP_CLR_NEGATIVE = 6'h24,
        BBSE_OP_SET_ZERO = 6'h25,
        BBSE_OP_CLR_ZERO = 6'h26,
        BBSE_OP_SET_SIGNED = 6'h27,
        BBSE_OP_CLR_SIGNED = 6'h28,
        BBSE_OP_SET_OVERFLOW = 6'h29,
        BBSE_OP_CLR_OVERFLOW = 6'h2a,
        BBSE_OP_GLOBAL_INT_ON = 6'h2b,
        BBSE_OP_GLOBAL_INT_OFF = 6'h2c
    } bbse_op_t;

    typedef enum logic [1:0] {
        BBSE_ST_IDLE = 2'h1,
        BBSE_ST_EXEC = 2'h2
    } bbse_fsm_t;

    typedef struct packed {
        bbse_fsm_t fsm;
        logic [1:0] cnt;
        logic [1:0] cost;
        logic taken;
        logic done;
        logic [16:0] cmd;
        logic [7:0] status_flags_register;
        logic [15:0] pc;
        logic [7:0] opnd;
        logic [7:0] ioval;
        logic [31:0] rdata;
        logic slverr;
    } bbse_state_t;

endpackage : bbse_pkg

// [rtl/bbse_core.sv]
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "bbse_regs.svh"

module bbse_core (
    // Clock, reset and enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Execution state
    output logic busy_out
);
    import bbse_pkg::*;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------

    // Returns {is_branch, taken} for every conditional branch.
    function automatic logic [1:0] branch_eval(input bbse_op_t op, input logic [2:0] s,
                                               input logic [7:0] f);
        logic nxv;
        nxv = f[`BBSE_FLAG_N] ^ f[`BBSE_FLAG_V];
        case (op)
            // RL2 generic flag test
            BBSE_OP_BRANCH_ON_FLAG_HIGH: branch_eval = {1'b1, f[s]};
            BBSE_OP_BRANCH_ON_FLAG_LOW: branch_eval = {1'b1, ~f[s]};
            // RL3 zero flag
            BBSE_OP_BRANCH_ZERO_HIGH: branch_eval = {1'b1, f[`BBSE_FLAG_Z]};
            BBSE_OP_BRANCH_ZERO_LOW: branch_eval = {1'b1, ~f[`BBSE_FLAG_Z]};
            // RL4 carry flag
            BBSE_OP_BRANCH_CARRY_HIGH: branch_eval = {1'b1, f[`BBSE_FLAG_C]};
            BBSE_OP_BRANCH_UNSIGNED_LT: branch_eval = {1'b1, f[`BBSE_FLAG_C]};
            BBSE_OP_BRANCH_CARRY_LOW: branch_eval = {1'b1, ~f[`BBSE_FLAG_C]};
            BBSE_OP_BRANCH_UNSIGNED_GE: branch_eval = {1'b1, ~f[`BBSE_FLAG_C]};
            // RL5 negative flag
            BBSE_OP_BRANCH_NEGATIVE: branch_eval = {1'b1, f[`BBSE_FLAG_N]};
            BBSE_OP_BRANCH_POSITIVE: branch_eval = {1'b1, ~f[`BBSE_FLAG_N]};
            // RL6 signed compare
            BBSE_OP_BRANCH_SIGNED_GE: branch_eval = {1'b1, ~nxv};
            BBSE_OP_BRANCH_SIGNED_LT: branch_eval = {1'b1, nxv};
            // RL7 half carry
            BBSE_OP_BRANCH_HALFCARRY_HIGH: branch_eval = {1'b1, f[`BBSE_FLAG_H]};
            BBSE_OP_BRANCH_HALFCARRY_LOW: branch_eval = {1'b1, ~f[`BBSE_FLAG_H]};
            // RL8 T flag
            BBSE_OP_BRANCH_TFLAG_HIGH: branch_eval = {1'b1, f[`BBSE_FLAG_T]};
            BBSE_OP_BRANCH_TFLAG_LOW: branch_eval = {1'b1, ~f[`BBSE_FLAG_T]};
            // RL9 overflow flag
            BBSE_OP_BRANCH_OVERFLOW_HIGH: branch_eval = {1'b1, f[`BBSE_FLAG_V]};
            BBSE_OP_BRANCH_OVERFLOW_LOW: branch_eval = {1'b1, ~f[`BBSE_FLAG_V]};
            // RL10 interrupt flag
            BBSE_OP_BRANCH_INT_ENABLED: branch_eval = {1'b1, f[`BBSE_FLAG_I]};
            BBSE_OP_BRANCH_INT_DISABLED: branch_eval = {1'b1, ~f[`BBSE_FLAG_I]};
            default: branch_eval = 2'h0;
        endcase
    endfunction : branch_eval

    // Returns {is_flag_op, flag index, value} for set and clear instructions.
    function automatic logic [4:0] flag_eval(input bbse_op_t op, input logic [2:0] s);
        case (op)
            BBSE_OP_FLAG_SET: flag_eval = {1'b1, s, 1'b1};
            BBSE_OP_FLAG_CLEAR: flag_eval = {1'b1, s, 1'b0};
            BBSE_OP_SET_CARRY: flag_eval = {1'b1, `BBSE_FLAG_C, 1'b1};
            BBSE_OP_CLR_CARRY: flag_eval = {1'b1, `BBSE_FLAG_C, 1'b0};
            BBSE_OP_SET_NEGATIVE: flag_eval = {1'b1, `BBSE_FLAG_N, 1'b1};
            BBSE_OP_CLR_NEGATIVE: flag_eval = {1'b1, `BBSE_FLAG_N, 1'b0};
            BBSE_OP_SET_ZERO: flag_eval = {1'b1, `BBSE_FLAG_Z, 1'b1};
            BBSE_OP_CLR_ZERO: flag_eval = {1'b1, `BBSE_FLAG_Z, 1'b0};
            BBSE_OP_SET_SIGNED: flag_eval = {1'b1, `BBSE_FLAG_S, 1'b1};
            BBSE_OP_CLR_SIGNED: flag_eval = {1'b1, `BBSE_FLAG_S, 1'b0};
            BBSE_OP_SET_OVERFLOW: flag_eval = {1'b1, `BBSE_FLAG_V, 1'b1};
            BBSE_OP_CLR_OVERFLOW: flag_eval = {1'b1, `BBSE_FLAG_V, 1'b0};
            BBSE_OP_GLOBAL_INT_ON: flag_eval = {1'b1, `BBSE_FLAG_I, 1'b1};
            BBSE_OP_GLOBAL_INT_OFF: flag_eval = {1'b1, `BBSE_FLAG_I, 1'b0};
            default: flag_eval = 5'h00;
        endcase
    endfunction : flag_eval

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    bbse_state_t s_r;
    bbse_state_t s_nxt;

    logic setup;
    logic access;
    logic busy;
    logic wr_ok;

    assign setup = psel_in & ~penable_in;
    assign access = psel_in & penable_in;
    assign busy = (s_r.fsm == BBSE_ST_EXEC);
    // Data registers are locked while an instruction is running.
    assign wr_ok = access & pwrite_in & ~busy;

    assign pready_out = ce_in;
    assign prdata_out = s_r.rdata;
    assign pslverr_out = s_r.slverr;
    assign busy_out = busy;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        bbse_op_t op;
        logic [2:0] bsel;
        logic [15:0] ofs;
        logic two_word;
        logic [7:0] f;
        logic [7:0] rd;
        logic [7:0] res;
        logic [1:0] br;
        logic [4:0] fl;
        logic shift_op;
        logic cout;
        logic [1:0] cost;
        logic taken;
        logic [15:0] pc_new;
        logic [31:0] rd_word;
        logic hit;
        op = bbse_op_t'(pwdata_in[`BBSE_CMD_OP_LSB +: 6]);
        bsel = pwdata_in[`BBSE_CMD_BIT_LSB +: 3];
        // RL20 signed 7-bit word offset
        ofs = {{9{pwdata_in[`BBSE_CMD_OFS_LSB + 6]}}, pwdata_in[`BBSE_CMD_OFS_LSB +: 7]};
        two_word = pwdata_in[`BBSE_CMD_TWO_WORD];
        f = s_r.status_flags_register;
        rd = s_r.opnd;
        res = rd;
        shift_op = 1'b1;
        cout = 1'b0;
        cost = `BBSE_COST_ONE;
        taken = 1'b0;
        pc_new = s_r.pc + 16'h0001;
        br = branch_eval(op, bsel, f);
        fl = flag_eval(op, bsel);
        rd_word = 32'h0000_0000;
        hit = 1'b1;
        s_nxt = s_r;

        // Read data and error are latched in the setup cycle.
        case (paddr_in)
            `BBSE_ADDR_CMD: rd_word = {15'h0000, s_r.cmd};
            `BBSE_ADDR_FLAGS: rd_word = {24'h000000, s_r.status_flags_register};
            `BBSE_ADDR_PC: rd_word = {16'h0000, s_r.pc};
            `BBSE_ADDR_OPND: rd_word = {24'h000000, s_r.opnd};
            `BBSE_ADDR_IOVAL: rd_word = {24'h000000, s_r.ioval};
            `BBSE_ADDR_STAT: rd_word = {26'h0000000, s_r.cost, 1'b0, s_r.taken, s_r.done, busy};
            default: hit = 1'b0;
        endcase
        if (setup) begin
            s_nxt.rdata = pwrite_in ? 32'h0000_0000 : rd_word;
            s_nxt.slverr = ~hit;
        end

        // Shift and rotate results.
        case (op)
            // RL12 left shift
            BBSE_OP_SHIFT_LEFT_LOGICAL: begin
                res = {rd[6:0], 1'b0};
                cout = rd[7];
            end
            // RL13 right shift
            BBSE_OP_SHIFT_RIGHT_LOGICAL: begin
                res = {1'b0, rd[7:1]};
                cout = rd[0];
            end
            // RL14 rotate left
            BBSE_OP_ROTATE_LEFT_CARRY: begin
                res = {rd[6:0], f[`BBSE_FLAG_C]};
                cout = rd[7];
            end
            // RL15 rotate right
            BBSE_OP_ROTATE_RIGHT_CARRY: begin
                res = {f[`BBSE_FLAG_C], rd[7:1]};
                cout = rd[0];
            end
            // RL16 arithmetic shift
            BBSE_OP_SHIFT_RIGHT_ARITH: begin
                res = {rd[7], rd[7:1]};
                cout = rd[0];
            end
            default: shift_op = 1'b0;
        endcase

        // Status bits: done is set on completion and cleared by writing one.
        if (access && pwrite_in && paddr_in == `BBSE_ADDR_STAT && pwdata_in[`BBSE_STAT_DONE]) begin
            s_nxt.done = 1'b0;
        end

        // Plain register writes.
        if (wr_ok) begin
            case (paddr_in)
                `BBSE_ADDR_FLAGS: s_nxt.status_flags_register = pwdata_in[7:0];
                `BBSE_ADDR_PC: s_nxt.pc = pwdata_in[15:0];
                `BBSE_ADDR_OPND: s_nxt.opnd = pwdata_in[7:0];
                `BBSE_ADDR_IOVAL: s_nxt.ioval = pwdata_in[7:0];
                default: s_nxt.cmd = s_r.cmd;
            endcase
        end

        case (s_r.fsm)
            BBSE_ST_IDLE: begin
                if (wr_ok && paddr_in == `BBSE_ADDR_CMD) begin
                    s_nxt.cmd = pwdata_in[16:0];
                    if (br[1]) begin
                        // RL2 taken costs two cycles
                        taken = br[0];
                        if (br[0]) begin
                            pc_new = s_r.pc + ofs + 16'h0001;
                            cost = `BBSE_COST_TWO;
                        end
                    end else if (op == BBSE_OP_SKIP_IF_IO_BIT_HIGH) begin
                        // RL1 skip over next instruction
                        taken = s_r.ioval[bsel];
                        if (taken) begin
                            // RL20 skip cost by length
                            pc_new = s_r.pc + (two_word ? 16'h0003 : 16'h0002);
                            cost = two_word ? `BBSE_COST_THREE : `BBSE_COST_TWO;
                        end
                    end else if (op == BBSE_OP_SET_IO_BIT || op == BBSE_OP_CLEAR_IO_BIT) begin
                        // RL11 single bit, two cycles
                        s_nxt.ioval[bsel] = (op == BBSE_OP_SET_IO_BIT);
                        cost = `BBSE_COST_TWO;
                    end else if (shift_op) begin
                        // RL12 flag update
                        s_nxt.opnd = res;
                        s_nxt.status_flags_register[`BBSE_FLAG_Z] = (res == 8'h00);
                        s_nxt.status_flags_register[`BBSE_FLAG_C] = cout;
                        s_nxt.status_flags_register[`BBSE_FLAG_N] = res[7];
                        s_nxt.status_flags_register[`BBSE_FLAG_V] = res[7] ^ cout;
                    end else if (op == BBSE_OP_BIT_STORE_TO_TFLAG) begin
                        // RL17 bit to T
                        s_nxt.status_flags_register[`BBSE_FLAG_T] = rd[bsel];
                    end else if (op == BBSE_OP_BIT_LOAD_FROM_TFLAG) begin
                        // RL17 T to bit
                        s_nxt.opnd[bsel] = f[`BBSE_FLAG_T];
                    end else if (fl[4]) begin
                        // RL18 single flag forced
                        // RL19 interrupt flag
                        s_nxt.status_flags_register[fl[3:1]] = fl[0];
                    end
                    s_nxt.pc = pc_new;
                    s_nxt.taken = taken;
                    s_nxt.cost = cost;
                    s_nxt.cnt = cost - 2'h1;
                    s_nxt.fsm = BBSE_ST_EXEC;
                end
            end
            BBSE_ST_EXEC: begin
                if (s_r.cnt == 2'h0) begin
                    s_nxt.fsm = BBSE_ST_IDLE;
                    s_nxt.done = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt - 2'h1;
                end
            end
            default: s_nxt.fsm = BBSE_ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_r.fsm <= BBSE_ST_IDLE;
            s_r.cnt <= 2'h0;
            s_r.cost <= 2'h0;
            s_r.taken <= 1'b0;
            s_r.done <= 1'b0;
            s_r.cmd <= 17'h00000;
            s_r.status_flags_register <= `BBSE_RST_FLAGS;
            s_r.pc <= `BBSE_RST_PC;
            s_r.opnd <= `BBSE_RST_BYTE;
            s_r.ioval <= `BBSE_RST_BYTE;
            s_r.rdata <= 32'h0000_0000;
            s_r.slverr <= 1'b0;
        end else if (ce_in) begin
            s_r <= s_nxt;
        end
    end

endmodule : bbse_core

// [verif/bbse_core_properties.sv]
`timescale 1ns/1ps

module bbse_core_properties (
    // Clock, reset and enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // APB slave side
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic busy_out
);
    logic mapped, setup, cmd_acc;
    assign mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= 8'h14);
    assign setup = psel_in && !penable_in && ce_in;
    assign cmd_acc = psel_in && penable_in && pwrite_in && (paddr_in == 8'h00);

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // ----
    // Command launch, busy, bus error, stall and reset checks
    // ----
    sequence seq_cmd_write;
        cmd_acc && pready_out;
    endsequence
    sequence seq_launch;
        seq_cmd_write ##0 !busy_out;
    endsequence

    a_io_bit_two: assert property (seq_launch ##0 pwdata_in[5:1] == 5'h0b
        |=> busy_out[*2] ##1 !busy_out)
        else $error("bit write not two cycles");
    a_launch_sets_busy: assert property (seq_launch |=> busy_out)
        else $error("launch left busy low");
    a_busy_has_cause: assert property ($rose(busy_out) |-> $past(cmd_acc))
        else $error("busy without command");
    a_busy_ends_soon: assert property ($rose(busy_out) |-> ##[1:3] !busy_out)
        else $error("busy over three cycles");
    a_unmapped_error: assert property (setup && !mapped |=> pslverr_out)
        else $error("unmapped without error");
    a_mapped_no_error: assert property (setup && mapped |=> !pslverr_out)
        else $error("error on mapped");
    a_unmapped_reads_zero: assert property (setup && !mapped && !pwrite_in |=> prdata_out == 32'h0)
        else $error("unmapped read nonzero");
    a_stall_holds_data: assert property (psel_in && penable_in && !pready_out |=> $stable(prdata_out))
        else $error("prdata moved in stall");
    a_reset_clears: assert property (disable iff (1'b0)
        rst_in && ce_in |=> !busy_out && !pslverr_out && prdata_out == 32'h0)
        else $error("reset left outputs");
endmodule : bbse_core_properties

bind bbse_core bbse_core_properties u_bbse_props (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .busy_out(busy_out)
);

// [verif/branch_bit_shift_exec_tb.sv]
`timescale 1ns/1ps
`include "bbse_regs.svh"

module branch_bit_shift_exec_tb;
    logic clk_in, rst_in, ce_in, psel_in, penable_in, pwrite_in, er;
    logic pready_out, pslverr_out, busy_out;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    int fail_count, checks;
    logic [7:0] f, o, io, ef, eo, eio;
    logic [15:0] p, ep;
    logic [1:0] ec;
    logic etk, br;
    logic [7:0] fv [3] = '{8'h55, 8'haa, 8'h0c};
    logic [7:0] ov [3] = '{8'h81, 8'h80, 8'h00};
    logic [7:0] iov [3] = '{8'h5a, 8'ha5, 8'h0f};
    logic [15:0] pv [3] = '{16'h0010, 16'hfff0, 16'h1234};
    logic [6:0] kv [3] = '{7'h40, 7'h3f, 7'h7f};

    bbse_core DUT (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .busy_out(busy_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task summarize;
        $display("mismatches %0d, checks %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task chk(input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            fail_count++;
            $display("[FAIL] %0t: seen %h expected %h", $time, s, x);
        end
    endtask : chk

    // ----
    // Bus cycles
    // ----
    // Keep leaves psel high so the next setup follows at once.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic keep);
        int n;
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            summarize();
        end
        rd = prdata_out;
        er = pslverr_out;
        if (!keep) begin
            psel_in <= 1'b0;
            penable_in <= 1'b0;
            @(posedge clk_in);
        end
    endtask : apb

    task rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, 1'b0);
        chk(rd, x);
    endtask : rdc

    task wait_idle;
        int n;
        n = 0;
        while (busy_out !== 1'b0 && n < 10) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 10) begin
            fail_count++;
            summarize();
        end
    endtask : wait_idle

    // ----
    // Reference behaviour
    // ----
    task model(input logic [5:0] op, input logic [2:0] b, input logic [6:0] k, input logic tw);
        logic c;
        logic cy;
        ef = f;
        eo = o;
        eio = io;
        ep = p + 16'h1;
        ec = 2'h1;
        etk = 1'b0;
        br = 1'b0;
        c = 1'b0;
        case (op)
            6'h01: begin
                br = 1'b1;
                etk = io[b];
                if (etk) begin
                    ep = p + 16'h2 + tw;
                    ec = 2'h2 + tw;
                end
            end
            6'h02, 6'h03: c = f[b] ^ op[0];
            6'h04, 6'h05: c = f[1] ^ op[0];
            6'h06, 6'h07: c = f[0] ^ op[0];
            6'h08, 6'h09: c = f[0] ^ !op[0];
            6'h0a, 6'h0b: c = f[2] ^ op[0];
            6'h0c, 6'h0d: c = f[2] ^ f[3] ^ !op[0];
            6'h0e, 6'h0f: c = f[5] ^ op[0];
            6'h10, 6'h11: c = f[6] ^ op[0];
            6'h12, 6'h13: c = f[3] ^ op[0];
            6'h14, 6'h15: c = f[7] ^ op[0];
            6'h16, 6'h17: begin
                eio[b] = !op[0];
                ec = 2'h2;
            end
            6'h18: eo = {o[6:0], 1'b0};
            6'h19: eo = {1'b0, o[7:1]};
            6'h1a: eo = {o[6:0], f[0]};
            6'h1b: eo = {f[0], o[7:1]};
            6'h1c: eo = {o[7], o[7:1]};
            6'h1d: ef[6] = o[b];
            6'h1e: eo[b] = f[6];
            6'h1f, 6'h20: ef[b] = op[0];
            6'h21, 6'h22: ef[0] = op[0];
            6'h23, 6'h24: ef[2] = op[0];
            6'h25, 6'h26: ef[1] = op[0];
            6'h27, 6'h28: ef[4] = op[0];
            6'h29, 6'h2a: ef[3] = op[0];
            6'h2b, 6'h2c: ef[7] = op[0];
            default: ;
        endcase
        if (op >= 6'h02 && op <= 6'h15) begin
            br = 1'b1;
            etk = c;
            if (c) begin
                ep = p + {{9{k[6]}}, k} + 16'h1;
                ec = 2'h2;
            end
        end
        if (op >= 6'h18 && op <= 6'h1c) begin
            cy = (op == 6'h18 || op == 6'h1a) ? o[7] : o[0];
            ef[0] = cy;
            ef[1] = (eo == 8'h00);
            ef[2] = eo[7];
            ef[3] = eo[7] ^ cy;
        end
    endtask : model

    task run(input logic [5:0] op, input int i);
        logic [2:0] b;
        b = op[2:0] + i[2:0];
        f = fv[i];
        o = ov[i];
        io = iov[i];
        p = pv[i];
        apb(1'b1, `BBSE_ADDR_FLAGS, {24'h0, f}, 1'b0);
        apb(1'b1, `BBSE_ADDR_PC, {16'h0, p}, 1'b0);
        apb(1'b1, `BBSE_ADDR_OPND, {24'h0, o}, 1'b0);
        apb(1'b1, `BBSE_ADDR_IOVAL, {24'h0, io}, 1'b0);
        apb(1'b1, `BBSE_ADDR_CMD, {15'h0, i[0], kv[i], b, op}, 1'b0);
        wait_idle();
        model(op, b, kv[i], i[0]);
        apb(1'b0, `BBSE_ADDR_STAT, 32'h0, 1'b0);
        chk(rd & (br ? 32'h37 : 32'h33), {26'h0, ec, 1'b0, etk, 2'h2});
        rdc(`BBSE_ADDR_PC, {16'h0, ep});
        rdc(`BBSE_ADDR_FLAGS, {24'h0, ef});
        rdc(`BBSE_ADDR_OPND, {24'h0, eo});
        rdc(`BBSE_ADDR_IOVAL, {24'h0, eio});
    endtask : run

    // ----
    // Scenarios
    // ----
    task t_reset;
        for (int a = 0; a <= 8'h14; a += 4) begin
            rdc(a[7:0], 32'h0);
        end
        $display("t_reset done");
    endtask : t_reset

    task t_all_ops;
        for (int i = 0; i < 3; i++) begin
            for (int op = 0; op <= 8'h2c; op++) begin
                run(op[5:0], i);
            end
        end
        run(6'h3f, 0);
        $display("t_all_ops done");
    endtask : t_all_ops

    task t_busy_ignore;
        apb(1'b1, `BBSE_ADDR_IOVAL, 32'h01, 1'b0);
        apb(1'b1, `BBSE_ADDR_PC, 32'h0100, 1'b0);
        apb(1'b1, `BBSE_ADDR_CMD, {15'h0, 1'b1, 7'h0, 3'h0, 6'h01}, 1'b1);
        apb(1'b1, `BBSE_ADDR_PC, 32'hbeef, 1'b0);
        wait_idle();
        rdc(`BBSE_ADDR_PC, 32'h0103);
        apb(1'b1, `BBSE_ADDR_STAT, 32'h35, 1'b0);
        rdc(`BBSE_ADDR_STAT, 32'h36);
        apb(1'b1, `BBSE_ADDR_STAT, 32'h2, 1'b0);
        rdc(`BBSE_ADDR_STAT, 32'h34);
        $display("t_busy_ignore done");
    endtask : t_busy_ignore

    task t_unmapped;
        apb(1'b1, 8'h18, 32'hffffffff, 1'b0);
        chk(er, 1'b1);
        apb(1'b0, 8'h18, 32'h0, 1'b0);
        chk({rd[31:1], er}, 32'h1);
        apb(1'b0, 8'h02, 32'h0, 1'b0);
        chk(er, 1'b1);
        apb(1'b0, `BBSE_ADDR_FLAGS, 32'h0, 1'b0);
        chk(er, 1'b0);
        $display("t_unmapped done");
    endtask : t_unmapped

    task t_stall;
        ce_in <= 1'b0;
        fork
            apb(1'b1, `BBSE_ADDR_PC, 32'h00a5, 1'b0);
            begin
                repeat (3) @(posedge clk_in);
                chk(pready_out, 1'b0);
                ce_in <= 1'b1;
            end
        join
        rdc(`BBSE_ADDR_PC, 32'h00a5);
        $display("t_stall done");
    endtask : t_stall

    initial begin
        rst_in = 1'b1;
        ce_in = 1'b1;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        fail_count = 0;
        checks = 0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_reset();
        t_all_ops();
        t_busy_ignore();
        t_unmapped();
        t_stall();
        summarize();
    end
endmodule : branch_bit_shift_exec_tb
